//--- hdl/rsc_pkg.sv
/*
 * Constants shared by the reset and sleep controller: register offsets, status
 * bit positions, reset values, the sleep opcode and the delay timing.
 * Assumes a 100 MHz system clock and a separate slow RC oscillator tick input.
 */
package rsc_pkg;
	localparam logic [7:0]  STATUS_OFS   = 8'h03;
	localparam int          TO_BIT       = 4;
	localparam int          PD_BIT       = 3;
	localparam logic [7:0]  STATUS_POR   = 8'h18;
	localparam logic [7:0]  ALL_ONES     = 8'hFF;
	localparam logic [11:0] SLEEP_OPCODE = 12'h003;
	localparam int          PTR_WIDTH    = 5;
	// APB byte addresses of the controller's own registers.
	localparam logic [7:0]  A_STATUS     = 8'h0C;
	localparam logic [7:0]  A_CTRL       = 8'h00;
	localparam logic [7:0]  A_STATE      = 8'h04;
	localparam logic [7:0]  A_IRQ_STAT   = 8'h08;
	localparam logic [7:0]  A_IRQ_MASK   = 8'h10;
	localparam logic [7:0]  A_SNAP       = 8'h14;
	// Interrupt event bit positions.
	localparam int          EV_SLEEP     = 0;
	localparam int          EV_WAKE      = 1;
	localparam int          EV_WDT       = 2;
	localparam int          EV_READY     = 3;
	localparam int          EV_NUM       = 4;
	// Delay timing: 18 ms counted on an RC tick of nominally 10 us.
	localparam int          DELAY_US     = 18000;
	localparam int          RC_TICK_US   = 10;
	localparam int          DELAY_TICKS  = DELAY_US / RC_TICK_US;
	localparam int          CNT_W        = 12;
	typedef enum logic [1:0] {ST_RESET, ST_DELAY, ST_RUN, ST_SLEEP} rsc_state_e;
endpackage

//--- hdl/rsc_delay_timer.sv
/*
 * Reset delay timer counting slow RC oscillator ticks.
 * Assumes rcTick is a one-cycle pulse synchronous to clk from the RC oscillator.
 */
`timescale 1ns/1ps
`default_nettype none
module rsc_delay_timer
	import rsc_pkg::*;
#(
	parameter int TICKS = DELAY_TICKS
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic restart,
	input  wire logic rcTick,
	output logic      expired
);
	logic [CNT_W-1:0] count_q;

	// Restart reloads; each RC tick counts down, so the main clock rate never matters.
	always_ff @(posedge clk) begin
		if (rst || restart) begin
			count_q <= CNT_W'(TICKS);
			expired <= 1'b0;
		end else if (rcTick && count_q != '0) begin
			count_q <= count_q - CNT_W'(1);
			expired <= (count_q == CNT_W'(1));
		end
	end
endmodule
`default_nettype wire

//--- hdl/rsc_reset_sleep.sv
/*
 * Reset and sleep controller top: reset pin and watchdog handling, delay timer,
 * status flags, reset values of core registers and an APB register slave.
 * Assumes all inputs synchronous to clk; rst is the power-on reset.
 */
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_sleep
	import rsc_pkg::*;
#(
	parameter int TICKS = DELAY_TICKS
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        externalResetPinN,
	input  wire logic        watchdogTimeout,
	input  wire logic        watchdogEnable,
	input  wire logic        prescalerToWatchdog,
	input  wire logic        rcTick,
	input  wire logic        instrValid,
	input  wire logic [11:0] instrWord,
	input  wire logic [7:0]  ioDriveIn,
	input  wire logic [7:0]  ioEnableIn,
	input  wire logic [2:0]  arithFlags,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	output logic             cpuReset,
	output logic             oscRun,
	output logic             watchdogClear,
	output logic             prescalerClear,
	output logic             resetPinDriveEn,
	output logic [7:0]       ioDriveOut,
	output logic [7:0]       ioEnableOut,
	output logic [7:0]       processorStatus,
	output logic [7:0]       directionControl,
	output logic [7:0]       programCounterLow,
	output logic [7:0]       indirectPointer,
	output logic             irq
);
	rsc_state_e          state_q;
	logic                timeoutFlag_q;
	logic                powerdownFlag_q;
	logic                timeoutFlag_d;
	logic                powerdownFlag_d;
	logic                restartDelay;
	logic                delayDone;
	logic                sleepExec;
	logic                wakeEvent;
	logic                wdtEvent;
	logic [EV_NUM-1:0]   events;
	logic [EV_NUM-1:0]   irqStat_q;
	logic [EV_NUM-1:0]   irqMask_q;
	logic                forceReset_q;
	logic                apbAccess;
	logic                statRead;
	logic [7:0]          ptrReset;

	// Sleep is recognised only while running, by its fixed encoding.
	assign sleepExec = (state_q == ST_RUN) && instrValid
		&& (instrWord == SLEEP_OPCODE);
	// A watchdog time-out counts only when the watchdog is enabled.
	assign wdtEvent  = watchdogTimeout && watchdogEnable;
	assign wakeEvent = (state_q == ST_SLEEP) && (!externalResetPinN || wdtEvent);
	// Every reset source, including a software forced reset, relaunches the timer.
	assign restartDelay = !externalResetPinN || wdtEvent || forceReset_q;
	// Unimplemented pointer bits above the implemented width read as one.
	assign ptrReset = ALL_ONES << PTR_WIDTH;
	assign apbAccess = psel && penable;
	// Clear on the edge that snapshots the read data, so no event is lost in between.
	assign statRead  = apbAccess && !pready && !pwrite && (paddr == A_IRQ_STAT);
	assign events = {
		(state_q == ST_DELAY) && delayDone,
		wdtEvent,
		wakeEvent,
		sleepExec
	};

	rsc_delay_timer #(
		.TICKS   (TICKS)
	) u_delay (
		.clk     (clk),
		.rst     (rst),
		.restart (restartDelay),
		.rcTick  (rcTick),
		.expired (delayDone)
	);

	// Sequencer: reset held while the pin is low, then the delay, then run.
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q  <= ST_RESET;
			cpuReset <= 1'b1;
		end else begin
			if (restartDelay) begin
				state_q  <= externalResetPinN ? ST_DELAY : ST_RESET;
				cpuReset <= 1'b1;
			end else unique case (state_q)
				ST_RESET: begin
					state_q <= ST_DELAY;
				end
				ST_DELAY: begin
					if (delayDone) begin
						state_q  <= ST_RUN;
						cpuReset <= 1'b0;
					end
				end
				ST_RUN: begin
					if (sleepExec) begin
						state_q <= ST_SLEEP;
					end
				end
				ST_SLEEP: begin
					state_q <= ST_SLEEP;
				end
			endcase
		end
	end

	// Oscillator driver stops in sleep; restarts with the reset delay.
	always_ff @(posedge clk) begin
		if (rst) begin
			oscRun <= 1'b1;
		end else if (wakeEvent || restartDelay) begin
			oscRun <= 1'b1;
		end else if (sleepExec) begin
			oscRun <= 1'b0;
		end
	end

	// Watchdog clear pulses on sleep entry and on wake-up; prescaler clear pulses only on sleep entry with the prescaler on the watchdog.
	always_ff @(posedge clk) begin
		if (rst) begin
			watchdogClear  <= 1'b0;
			prescalerClear <= 1'b0;
		end else begin
			watchdogClear  <= sleepExec || wakeEvent;
			prescalerClear <= sleepExec && prescalerToWatchdog;
		end
	end

	// The watchdog reset stays internal; the pin driver is never enabled.
	always_ff @(posedge clk) begin
		resetPinDriveEn <= 1'b0;
	end

	// I/O drive state is frozen while asleep so pins keep their level.
	always_ff @(posedge clk) begin
		if (rst) begin
			ioDriveOut  <= 8'h00;
			ioEnableOut <= 8'h00;
		end else if (state_q != ST_SLEEP || wakeEvent) begin
			ioDriveOut  <= ioDriveIn;
			ioEnableOut <= ioEnableIn;
		end else begin
			ioDriveOut  <= ioDriveOut;
			ioEnableOut <= ioEnableOut;
		end
	end

	// Next flag values, shared with the status image so it never lags the flags.
	always_comb begin
		timeoutFlag_d   = timeoutFlag_q;
		powerdownFlag_d = powerdownFlag_q;
		if (wdtEvent) begin
			timeoutFlag_d = 1'b0;
		end else if (sleepExec) begin
			timeoutFlag_d = 1'b1;
		end
		if (sleepExec) begin
			powerdownFlag_d = 1'b0;
		end
	end

	// Timeout and powerdown flags; a watchdog event wins over a sleep set.
	always_ff @(posedge clk) begin
		if (rst) begin
			timeoutFlag_q   <= 1'b1;
			powerdownFlag_q <= 1'b1;
		end else begin
			timeoutFlag_q   <= timeoutFlag_d;
			powerdownFlag_q <= powerdownFlag_d;
		end
	end

	// Core register reset values; arithmetic bits pass through and stay unchanged.
	always_ff @(posedge clk) begin
		if (rst) begin
			processorStatus   <= STATUS_POR;
			directionControl  <= ALL_ONES;
			programCounterLow <= ALL_ONES;
			indirectPointer   <= ptrReset;
		end else begin
			processorStatus <= {3'b000, timeoutFlag_d, powerdownFlag_d, arithFlags};
			if (restartDelay) begin
				directionControl  <= ALL_ONES;
				programCounterLow <= ALL_ONES;
				indirectPointer   <= indirectPointer | ptrReset;
			end
		end
	end

	// Sticky event bits, cleared by reading; a new event in that cycle wins.
	always_ff @(posedge clk) begin
		if (rst) begin
			irqStat_q <= '0;
		end else begin
			irqStat_q <= (statRead ? '0 : irqStat_q) | events;
		end
	end

	// Interrupt output is high while any unmasked status bit is set.
	always_ff @(posedge clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irqStat_q & irqMask_q);
		end
	end

	// APB writes: mask register and a self-clearing forced reset bit.
	always_ff @(posedge clk) begin
		if (rst) begin
			irqMask_q    <= '0;
			forceReset_q <= 1'b0;
		end else begin
			forceReset_q <= 1'b0;
			// Writes land only on the edge at which the master sees pready high.
			if (apbAccess && pready && pwrite && paddr == A_IRQ_MASK) begin
				irqMask_q <= pwdata[EV_NUM-1:0];
			end
			if (apbAccess && pready && pwrite && paddr == A_CTRL) begin
				forceReset_q <= pwdata[0];
			end
		end
	end

	// APB answer: one wait state, so pready is high in the second access cycle.
	always_ff @(posedge clk) begin
		if (rst) begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= 1'b0;
			prdata  <= '0;
			if (psel && penable && !pready) begin
				unique case (paddr)
					A_CTRL:     prdata <= '0;
					A_STATE:    prdata <= {29'h0, cpuReset, 2'(state_q)};
					A_IRQ_STAT: prdata <= {28'h0, irqStat_q};
					A_STATUS:   prdata <= {24'h0, processorStatus};
					A_IRQ_MASK: prdata <= {28'h0, irqMask_q};
					A_SNAP:     prdata <= {16'h0, directionControl, indirectPointer};
					default:    pslverr <= 1'b1;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

//--- testbench/rsc_reset_sleep_monitor.sv
/* Port assertions for the reset and sleep controller.
   Bound to every rsc_reset_sleep instance; TICKS follows the instance. */
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_sleep_monitor
	import rsc_pkg::*;
#(
	parameter int TICKS = DELAY_TICKS
) (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        externalResetPinN,
	input wire logic        watchdogTimeout,
	input wire logic        watchdogEnable,
	input wire logic        prescalerToWatchdog,
	input wire logic        rcTick,
	input wire logic        instrValid,
	input wire logic [11:0] instrWord,
	input wire logic        cpuReset,
	input wire logic        oscRun,
	input wire logic        watchdogClear,
	input wire logic        prescalerClear,
	input wire logic        resetPinDriveEn,
	input wire logic [7:0]  ioDriveOut,
	input wire logic [7:0]  processorStatus,
	input wire logic [7:0]  directionControl,
	input wire logic [7:0]  programCounterLow,
	input wire logic [7:0]  indirectPointer
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [15:0] ticks_q;
	// Ticks since the latest pin or watchdog reset cause; missing a forced reset cause only makes the bound looser.
	always_ff @(posedge clk) begin
		if (rst || !externalResetPinN || (watchdogTimeout && watchdogEnable))
			ticks_q <= 16'h0000;
		else if (rcTick && ticks_q != 16'hFFFF)
			ticks_q <= ticks_q + 16'h0001;
	end
	sequence sleep_cmd;
		instrValid && instrWord == SLEEP_OPCODE && oscRun && !cpuReset
			&& externalResetPinN && !watchdogTimeout;
	endsequence
	sequence quiet_sleep;
		(!oscRun && externalResetPinN && !watchdogTimeout) [*3];
	endsequence
	pin_never_driven_a: assert property (!resetPinDriveEn)
		else $error("reset pin driven");
	pin_holds_core_a: assert property (!externalResetPinN |=> cpuReset)
		else $error("core not held");
	delay_length_a: assert property ($fell(cpuReset) |-> ticks_q >= TICKS)
		else $error("delay too short");
	sleep_entry_a: assert property (sleep_cmd |=> !oscRun && watchdogClear
		&& processorStatus[TO_BIT] && !processorStatus[PD_BIT])
		else $error("sleep entry wrong");
	prescaler_clear_a: assert property (sleep_cmd ##0 prescalerToWatchdog |=> prescalerClear)
		else $error("prescaler kept");
	wdt_flag_a: assert property (watchdogTimeout && watchdogEnable |=> !processorStatus[TO_BIT])
		else $error("timeout flag kept");
	io_frozen_a: assert property (quiet_sleep |=> $stable(ioDriveOut))
		else $error("pins moved in sleep");
	stay_asleep_a: assert property (quiet_sleep |=> !oscRun)
		else $error("woke without cause");
	wake_clear_a: assert property (!oscRun && (!externalResetPinN
		|| watchdogTimeout && watchdogEnable) |-> ##[1:2] watchdogClear)
		else $error("no clear on wake");
	reset_values_a: assert property (cpuReset |-> directionControl == ALL_ONES
		&& programCounterLow == ALL_ONES && indirectPointer[7:5] == 3'b111)
		else $error("reset values wrong");
	status_top_a: assert property (processorStatus[7:5] == 3'b000)
		else $error("status top bits set");
endmodule
bind rsc_reset_sleep rsc_reset_sleep_monitor #(.TICKS(TICKS)) mon (.*);
`default_nettype wire

//--- testbench/rsc_far_side.sv
/* Far-side model: reset pin driver, watchdog and RC tick source.
   The bench steers it with two request levels changed after clk edges. */
`timescale 1ns/1ps
`default_nettype none
module rsc_far_side (
	input  wire logic clk,
	input  wire logic holdLow,
	input  wire logic fire,
	output logic      pinN,
	output logic      wdtOut,
	output logic      rcTick
);
	logic [1:0] div_q;
	// The pin starts low so the device powers up held in reset.
	initial begin
		pinN = 1'b0;
		wdtOut = 1'b0;
		rcTick = 1'b0;
		div_q = 2'h0;
	end
	// Released, the pin returns high through its pull-up; ticks come every fourth cycle.
	always @(posedge clk) begin
		pinN <= !holdLow;
		wdtOut <= fire;
		div_q <= div_q + 2'h1;
		rcTick <= div_q == 2'h3;
	end
endmodule
`default_nettype wire

//--- testbench/rsc_reset_sleep_tb.sv
/* Self-checking bench for the reset and sleep controller.
   Uses rsc_far_side for the pin, watchdog and ticks; APB master in tasks. */
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_sleep_tb;
	import rsc_pkg::*;
	localparam int T = 4;
	logic        clk = 1'b0, rst = 1'b1, holdLow = 1'b1, fire = 1'b0;
	logic        watchdogEnable = 1'b0, prescalerToWatchdog = 1'b0, instrValid = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq;
	logic        externalResetPinN, watchdogTimeout, rcTick, cpuReset, oscRun;
	logic        watchdogClear, prescalerClear, resetPinDriveEn;
	logic [11:0] instrWord = 12'h000;
	logic [7:0]  ioDriveIn = 8'h00, ioEnableIn = 8'h00, paddr = 8'h00;
	logic [7:0]  ioDriveOut, ioEnableOut, processorStatus, directionControl;
	logic [7:0]  programCounterLow, indirectPointer, d0, d1;
	logic [2:0]  arithFlags = 3'h0;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic        e;
	int          n_errors = 0, samples_checked = 0, seed = 32'hCA35, t;
	rsc_reset_sleep #(.TICKS(T)) dut (.*);
	rsc_far_side far (.clk(clk), .holdLow(holdLow), .fire(fire),
		.pinN(externalResetPinN), .wdtOut(watchdogTimeout), .rcTick(rcTick));
	always #5 clk = ~clk;
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer; an edge passes first so back-to-back calls never collide.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k == 50) begin
			n_errors++;
			report_and_stop();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Count ticks until the core leaves reset, with a bounded wait.
	task automatic wait_run();
		int k;
		t = 0;
		for (k = 0; k < 500 && cpuReset !== 1'b0; k++) begin
			@(posedge clk);
			t += int'(rcTick);
		end
		if (k == 500) begin
			n_errors++;
			report_and_stop();
		end
	endtask
	task automatic do_sleep(input logic [11:0] op);
		@(posedge clk);
		ioDriveIn <= 8'($random(seed));
		ioEnableIn <= 8'($random(seed));
		instrValid <= 1'b1;
		instrWord <= op;
		@(posedge clk);
		instrValid <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		arithFlags <= 3'($random(seed));
		repeat (20) @(posedge clk);
		chk(cpuReset, 1);
		chk(processorStatus[7:3], 5'b00011);
		chk({directionControl, programCounterLow}, 16'hFFFF);
		chk(indirectPointer[7:5], 3'b111);
		chk(resetPinDriveEn, 0);
		holdLow <= 1'b0;
		wait_run();
		chk(t >= T && t <= T + 1, 1);
		$display("test power-on done");
		apb(1'b1, A_IRQ_MASK, 32'h0);
		repeat (2) @(posedge clk);
		chk(irq, 0);
		apb(1'b1, A_IRQ_MASK, 32'hF);
		repeat (2) @(posedge clk);
		chk(irq, 1);
		apb(1'b0, A_IRQ_STAT, 32'h0);
		chk(r[EV_READY], 1);
		repeat (2) @(posedge clk);
		chk(irq, 0);
		apb(1'b0, A_STATUS, 32'h0);
		chk(r[7:0], {5'b00011, arithFlags});
		apb(1'b0, 8'h40, 32'h0);
		chk(e, 1);
		$display("test registers done");
		do_sleep(12'($random(seed)) | 12'h800);
		chk(oscRun, 1);
		prescalerToWatchdog <= 1'b1;
		do_sleep(SLEEP_OPCODE);
		chk(oscRun, 0);
		chk(processorStatus[4:3], 2'b10);
		d0 = ioDriveOut;
		d1 = ioEnableOut;
		ioDriveIn <= ~ioDriveIn;
		ioEnableIn <= ~ioEnableIn;
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		repeat (4) @(posedge clk);
		chk(ioDriveOut, d0);
		chk(ioEnableOut, d1);
		chk(oscRun, 0);
		watchdogEnable <= 1'b1;
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		repeat (3) @(posedge clk);
		chk(cpuReset, 1);
		wait_run();
		chk(t >= T - 1 && t <= T + 1, 1);
		chk(processorStatus[4:3], 2'b00);
		$display("test watchdog wake done");
		do_sleep(SLEEP_OPCODE);
		holdLow <= 1'b1;
		repeat (6) @(posedge clk);
		chk(cpuReset, 1);
		holdLow <= 1'b0;
		wait_run();
		chk(processorStatus[4:3], 2'b10);
		$display("test pin wake done");
		report_and_stop();
	end
endmodule
`default_nettype wire
